/* File: hw/pvp_fifo2.sv */
`timescale 1ns/1ps
// Small buffer with valid and ready on both sides
module pvp_fifo2 #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    // Storage and pointers
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // Honest full and empty
    assign in_ready = (cnt_ff != FULL);
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next pointers and fill level
    always_comb
    begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push)
            nxt_wr = (wr_ff == LAST) ? '0 : AW'(wr_ff + 1'b1);
        if (pop)
            nxt_rd = (rd_ff == LAST) ? '0 : AW'(rd_ff + 1'b1);
        if (push && !pop)
            nxt_cnt = (AW + 1)'(cnt_ff + 1'b1);
        else if (pop && !push)
            nxt_cnt = (AW + 1)'(cnt_ff - 1'b1);
    end

    // Register pointers
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Store words
    always_ff @(posedge mclk)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data;
    end
endmodule

/* File: hw/pvp_pkg.sv */
// Shared constants and types of the PCM voice port
package pvp_pkg;
    // Channel and word geometry
    localparam int NCH = 3;
    localparam int WORD_BITS = 16;
    localparam int SAMPLE_BITS = 13;
    localparam int PAD_BITS = 3;
    localparam int SLOT_W = 4;
    localparam int CH_W = 2;
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam logic [3:0] LONG_SYNC_BITS = 4'h3;
    localparam logic [2:0] MAX_SLOTS_LOG2 = 3'h4;
    // Repeats of one voice sample in the 48 kHz channel
    localparam logic [2:0] REP_8K = 3'h6;
    localparam logic [2:0] REP_16K = 3'h3;
    // Bit clock least half period
    localparam int MCLK_NS = 10;
    localparam int BCLK_MIN_NS = 41;
    localparam logic [7:0] HALF_MIN_CYC =
        8'((BCLK_MIN_NS + MCLK_NS - 1) / MCLK_NS);
    // Fill of the three unused bits
    typedef enum logic [1:0] {
        PVP_FILL_ZERO = 2'b00,
        PVP_FILL_ONES = 2'b01,
        PVP_FILL_SIGN = 2'b10,
        PVP_FILL_PROG = 2'b11
    } pvp_fill_e;
    // Transport state
    typedef enum logic [1:0] {
        PVP_IDLE = 2'b00,
        PVP_RUN = 2'b01,
        PVP_REFUSED = 2'b10
    } pvp_state_e;
endpackage

/* File: hw/pvp_sync2.sv */
`timescale 1ns/1ps
// Two flip-flop synchroniser for pin inputs
module pvp_sync2 #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // First stage, read only by the second
    logic [WIDTH-1:0] meta_ff;
    // Second stage
    logic [WIDTH-1:0] q_ff;

    // Register both stages
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_ff <= '0;
            q_ff <= '0;
        end
        else
        begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule

/* File: hw/pvp_voice_port.sv */
// How it works
// R1 - Master drives bit clock and sync; slave receives.
// R2 - Two ports; pins yield to shared sound port.
// R3 - Three full-duplex channels over up to sixteen slots.
// R4 - Slots per frame follow the chosen bit rate.
// R5 - One slot serves both directions of a channel.
// R6 - Data output released in every unused slot.
// R7 - Release after falling edge of slot's last bit.
// R8 - Short sync: one bit wide, before slot zero.
// R9 - Slave short sync: fall sample, start next rise.
// R10 - Long sync: three bits, starting with slot zero.
// R11 - Narrowband uses 13 bits, position and order configurable.
// R12 - Spare bits ignored inbound, filled outbound as configured.
// R13 - Reset format: 13 bits, left aligned, MSB first.
// R14 - Transparent wideband: 16-bit samples, master or slave.
// R15 - Codec wideband: linear 16-bit samples at 16 kHz.
// R16 - Multiplexed frame: voice, then FM left, right.
// R17 - Voice sample repeated six or three times.
// R18 - Sync pulse marks each multiplexed frame start.
// R19 - Host alone enables multiplexed mode.
// R20 - Mixed voice rates only when this end masters.
// R21 - More channels need a faster bit clock.
// R22 - Mode changes only while transport is stopped.
// R23 - Counters reload at every frame sync.
`timescale 1ns/1ps
module pvp_voice_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Transport control
    input wire logic start,
    input wire logic i2s_own,
    // Configuration, taken when the transport starts
    input wire logic cfg_master,
    input wire logic cfg_long_sync,
    input wire logic [2:0] cfg_slots_log2,
    input wire logic [7:0] cfg_half,
    input wire logic cfg_wideband_voice,
    input wire logic cfg_lsb_first,
    input wire logic cfg_right_align,
    input wire logic [1:0] cfg_fill,
    input wire logic [2:0] cfg_fill_val,
    input wire logic [2:0] cfg_chan_en,
    input wire logic [11:0] cfg_chan_slot,
    input wire logic cfg_mux,
    input wire logic cfg_rate16,
    input wire logic cfg_mux_multi,
    // Transmit samples
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [1:0] tx_chan,
    input wire logic [15:0] tx_data,
    // Receive samples
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [1:0] rx_chan,
    output logic [15:0] rx_data,
    // Status
    output logic running,
    output logic cfg_err,
    output logic rx_overrun,
    input wire logic overrun_clr,
    // PCM pins
    input wire logic bclk_i,
    output logic bclk_o,
    output logic bclk_oe_n,
    input wire logic fsync_i,
    output logic fsync_o,
    output logic fsync_oe_n,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_n
);
    localparam int CFG_W = 39;
    localparam int W = pvp_pkg::WORD_BITS;

    // Transport state and latched configuration
    pvp_pkg::pvp_state_e state_ff, nxt_state;
    logic [CFG_W-1:0] cfg_ff, nxt_cfg, cfg_in;
    logic c_master, c_long, c_wide, c_lsb, c_right, c_mux, c_rate16;
    logic c_multi;
    logic [2:0] c_log2, c_fval, c_en;
    logic [7:0] c_half;
    logic [1:0] c_fill;
    logic [11:0] c_slot;
    // Bit clock generation and edge finding
    logic [7:0] div_ff, nxt_div, half;
    logic bclk_ff, nxt_bclk, bclk_d_ff, m_tog, rise, fall, run;
    logic [2:0] pins_s;
    // Frame position
    logic [3:0] bit_ff, nxt_bit, slot_ff, nxt_slot, last_slot;
    logic fresh_ff, nxt_fresh, pend_ff, nxt_pend, fsp_ff, nxt_fsp;
    logic at_end, reload, long_hit;
    logic [2:0] rep_ff, nxt_rep, rep_n;
    // Channel hits
    logic [2:0] hits;
    logic [1:0] ch;
    logic any;
    // Data path
    logic [W-1:0] hold_ff [pvp_pkg::NCH];
    logic [W-1:0] nxt_hold [pvp_pkg::NCH];
    logic [2:0] full_ff, nxt_full;
    logic [W-1:0] txsh_ff, nxt_txsh, rxsh_ff, nxt_rxsh, word, rxw;
    logic [pvp_pkg::SAMPLE_BITS-1:0] s13;
    logic dout_ff, nxt_dout, doe_n_ff, nxt_doe_n;
    logic fs_ff, nxt_fs, pin_oe_n_ff, nxt_pin_oe_n;
    logic push, push_ready, ovr_ff, nxt_ovr;
    logic [W+1:0] push_data;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Unpack the latched configuration
    assign cfg_in = {cfg_master, cfg_long_sync, cfg_slots_log2, cfg_half,
        cfg_wideband_voice, cfg_lsb_first, cfg_right_align, cfg_fill,
        cfg_fill_val, cfg_chan_en, cfg_chan_slot, cfg_mux, cfg_rate16,
        cfg_mux_multi};
    assign {c_master, c_long, c_log2, c_half, c_wide, c_lsb, c_right,
        c_fill, c_fval, c_en, c_slot, c_mux, c_rate16, c_multi} = cfg_ff;

    // Pins from outside pass two flip-flops
    pvp_sync2 #(.WIDTH(3)) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d({bclk_i, fsync_i, din_i}),
        .q(pins_s)
    );

    // Channels whose slot matches, with the first one chosen
    function automatic logic [2:0] slot_hits(input logic [3:0] s);
        logic [2:0] h;
        h = '0;
        for (int k = 0; k < pvp_pkg::NCH; k++)
        begin
            // R16 fixed order in multiplexed frame
            if (c_mux)
                h[k] = (s == 4'(k));
            else
                h[k] = c_en[k] &&
                    (s == c_slot[k*pvp_pkg::SLOT_W +: pvp_pkg::SLOT_W]);
        end
        return h;
    endfunction

    // Build the outgoing slot word from a held sample
    function automatic logic [W-1:0] tx_fmt(input logic [W-1:0] d);
        logic [pvp_pkg::PAD_BITS-1:0] f;
        logic [pvp_pkg::SAMPLE_BITS-1:0] s;
        s = d[pvp_pkg::SAMPLE_BITS-1:0];
        // R12 fill of spare bits
        case (pvp_pkg::pvp_fill_e'(c_fill))
            pvp_pkg::PVP_FILL_ZERO: f = '0;
            pvp_pkg::PVP_FILL_ONES: f = '1;
            pvp_pkg::PVP_FILL_SIGN:
                f = {pvp_pkg::PAD_BITS{s[pvp_pkg::SAMPLE_BITS-1]}};
            default: f = c_fval;
        endcase
        // R14 sixteen-bit words pass whole
        // R15 codec words also whole
        if (c_wide || c_mux)
            return d;
        // R11 position of the thirteen bits
        return c_right ? {f, s} : {s, f};
    endfunction

    // Start, stop and refusal of the transport
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cfg = cfg_ff;
        case (state_ff)
            pvp_pkg::PVP_IDLE:
                if (start)
                begin
                    // R20 mixed rates refused as slave
                    if (cfg_mux && cfg_mux_multi && !cfg_master)
                        nxt_state = pvp_pkg::PVP_REFUSED;
                    else
                    begin
                        // R22 config taken only from stop
                        nxt_state = pvp_pkg::PVP_RUN;
                        nxt_cfg = cfg_in;
                    end
                end
            pvp_pkg::PVP_RUN:
                if (!start)
                    nxt_state = pvp_pkg::PVP_IDLE;
            pvp_pkg::PVP_REFUSED:
                if (!start)
                    nxt_state = pvp_pkg::PVP_IDLE;
            default:
                nxt_state = pvp_pkg::PVP_IDLE;
        endcase
    end

    // Register the transport state
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= pvp_pkg::PVP_IDLE;
            // R13 narrow, left aligned, MSB first
            cfg_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cfg_ff <= nxt_cfg;
        end
    end

    assign run = (state_ff == pvp_pkg::PVP_RUN);
    // R4 frame length from slot count
    assign last_slot = 4'((5'h01 << ((c_log2 > pvp_pkg::MAX_SLOTS_LOG2) ?
        pvp_pkg::MAX_SLOTS_LOG2 : c_log2)) - 5'h01);
    assign half = (c_half < pvp_pkg::HALF_MIN_CYC) ?
        pvp_pkg::HALF_MIN_CYC : c_half;
    assign rep_n = c_rate16 ? pvp_pkg::REP_16K : pvp_pkg::REP_8K;
    assign tx_ready = (tx_chan < 2'(pvp_pkg::NCH)) && !full_ff[tx_chan];

    // Link side: clock, frame position, slot data
    always_comb
    begin
        nxt_div = '0;
        nxt_bclk = 1'b0;
        m_tog = 1'b0;
        // R21 host sets faster clock by half period
        if (run && c_master)
        begin
            nxt_bclk = bclk_ff;
            nxt_div = 8'(div_ff + 8'h01);
            if (div_ff >= 8'(half - 8'h01))
            begin
                nxt_div = '0;
                nxt_bclk = !bclk_ff;
                m_tog = 1'b1;
            end
        end
        // R1 own clock as master, pin clock as slave
        rise = run && (c_master ? (m_tog && !bclk_ff)
            : (pins_s[2] && !bclk_d_ff));
        fall = run && (c_master ? (m_tog && bclk_ff)
            : (!pins_s[2] && bclk_d_ff));
        at_end = (bit_ff == pvp_pkg::LAST_BIT) && (slot_ff == last_slot);
        // R23 reload at generated or detected sync
        reload = at_end || (c_master ? fresh_ff : pend_ff);
        long_hit = fall && !c_master && c_long && pins_s[1] && !fsp_ff;
        nxt_bit = bit_ff;
        nxt_slot = slot_ff;
        nxt_fresh = fresh_ff;
        nxt_pend = pend_ff;
        nxt_fsp = fsp_ff;
        nxt_rep = rep_ff;
        if (!run)
        begin
            nxt_bit = '0;
            nxt_slot = '0;
            nxt_fresh = 1'b1;
            nxt_pend = 1'b0;
            nxt_rep = '0;
        end
        else if (rise)
        begin
            nxt_pend = 1'b0;
            if (reload)
            begin
                nxt_bit = '0;
                nxt_slot = '0;
                if (c_master || pend_ff)
                    nxt_fresh = 1'b0;
                // R17 count repeats per multiplexed frame
                if (c_mux && !fresh_ff)
                    nxt_rep = (rep_ff == 3'(rep_n - 3'h1)) ? '0
                        : 3'(rep_ff + 3'h1);
            end
            else
            begin
                nxt_bit = 4'(bit_ff + 4'h1);
                if (bit_ff == pvp_pkg::LAST_BIT)
                    nxt_slot = 4'(slot_ff + 4'h1);
            end
        end
        else if (fall)
        begin
            // R9 short sync sampled on falling edge
            nxt_pend = !c_master && !c_long && pins_s[1];
            nxt_fsp = pins_s[1];
            // R10 long sync start is slot zero bit zero
            if (long_hit)
            begin
                nxt_bit = '0;
                nxt_slot = '0;
                nxt_fresh = 1'b0;
            end
        end
        // R3 up to three channels on the slots
        hits = slot_hits(nxt_slot) & {3{!nxt_fresh}};
        any = |hits;
        ch = hits[0] ? 2'h0 : (hits[1] ? 2'h1 : 2'h2);
        nxt_hold = hold_ff;
        nxt_full = full_ff;
        nxt_txsh = txsh_ff;
        nxt_rxsh = rxsh_ff;
        nxt_dout = dout_ff;
        nxt_doe_n = doe_n_ff;
        nxt_fs = fs_ff;
        word = txsh_ff;
        rxw = c_lsb ? {pins_s[0], rxsh_ff[W-1:1]}
            : {rxsh_ff[W-2:0], pins_s[0]};
        push = 1'b0;
        if (rise)
        begin
            if (any && nxt_bit == '0)
            begin
                word = tx_fmt(hold_ff[ch]);
                // R17 voice sample kept for all repeats
                if (!(c_mux && ch == 2'h0 && nxt_rep != 3'(rep_n - 3'h1)))
                    nxt_full[ch] = 1'b0;
            end
            nxt_txsh = word;
            nxt_dout = c_lsb ? word[nxt_bit] : word[4'(pvp_pkg::LAST_BIT
                - nxt_bit)];
            // R6 driven only in used slots
            nxt_doe_n = !any;
            // R8 short sync in last bit before frame
            // R18 every frame, multiplexed too
            nxt_fs = c_long ? (nxt_slot == '0 &&
                nxt_bit < pvp_pkg::LONG_SYNC_BITS)
                : (nxt_bit == pvp_pkg::LAST_BIT && nxt_slot == last_slot);
        end
        // R7 release after last falling edge
        if (fall && bit_ff == pvp_pkg::LAST_BIT)
            nxt_doe_n = 1'b1;
        // R2 pins yield to the sound port
        if (!run || i2s_own)
            nxt_doe_n = 1'b1;
        if (!run || !c_master)
            nxt_fs = 1'b0;
        // R5 same slot received as sent
        if (fall && any)
        begin
            nxt_rxsh = rxw;
            if (nxt_bit == pvp_pkg::LAST_BIT)
                push = !(c_mux && ch == 2'h0 && nxt_rep != '0);
        end
        // R12 spare bits dropped, sign extended
        s13 = c_right ? rxw[pvp_pkg::SAMPLE_BITS-1:0]
            : rxw[W-1:pvp_pkg::PAD_BITS];
        push_data = {ch, (c_wide || c_mux) ? rxw
            : {{pvp_pkg::PAD_BITS{s13[pvp_pkg::SAMPLE_BITS-1]}}, s13}};
        // Host writes win over consumption
        if (tx_valid && tx_ready)
        begin
            nxt_hold[tx_chan] = tx_data;
            nxt_full[tx_chan] = 1'b1;
        end
        // Overrun set wins over clear
        nxt_ovr = (ovr_ff && !overrun_clr) || (push && !push_ready);
        nxt_pin_oe_n = !(run && c_master && !i2s_own);
    end

    // Register link side state
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_ff <= '0;
            bclk_ff <= 1'b0;
            bclk_d_ff <= 1'b0;
            bit_ff <= '0;
            slot_ff <= '0;
            fresh_ff <= 1'b1;
            pend_ff <= 1'b0;
            fsp_ff <= 1'b0;
            rep_ff <= '0;
            for (int k = 0; k < pvp_pkg::NCH; k++)
                hold_ff[k] <= '0;
            full_ff <= '0;
            txsh_ff <= '0;
            rxsh_ff <= '0;
            dout_ff <= 1'b0;
            doe_n_ff <= 1'b1;
            fs_ff <= 1'b0;
            pin_oe_n_ff <= 1'b1;
            ovr_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            bclk_ff <= nxt_bclk;
            bclk_d_ff <= pins_s[2];
            bit_ff <= nxt_bit;
            slot_ff <= nxt_slot;
            fresh_ff <= nxt_fresh;
            pend_ff <= nxt_pend;
            fsp_ff <= nxt_fsp;
            rep_ff <= nxt_rep;
            hold_ff <= nxt_hold;
            full_ff <= nxt_full;
            txsh_ff <= nxt_txsh;
            rxsh_ff <= nxt_rxsh;
            dout_ff <= nxt_dout;
            doe_n_ff <= nxt_doe_n;
            fs_ff <= nxt_fs;
            pin_oe_n_ff <= nxt_pin_oe_n;
            ovr_ff <= nxt_ovr;
        end
    end

    // Two-entry buffer; a word arriving while both entries are full is lost and sets overrun
    pvp_fifo2 #(.WIDTH(W + 2), .DEPTH(2)) u_rxbuf (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data({rx_chan, rx_data})
    );

    // Outputs from flip-flops
    assign bclk_o = bclk_ff;
    assign bclk_oe_n = pin_oe_n_ff;
    assign fsync_o = fs_ff;
    assign fsync_oe_n = pin_oe_n_ff;
    assign dout_o = dout_ff;
    assign dout_oe_n = doe_n_ff;
    assign running = run;
    assign cfg_err = (state_ff == pvp_pkg::PVP_REFUSED);
    assign rx_overrun = ovr_ff;

    AST_SLAVE_PINS: assert property (run && !c_master |=> bclk_oe_n) // R1
        else $error("slave drives clock pin");
    AST_SHARED_PINS: assert property (i2s_own |=> dout_oe_n) // R2
        else $error("data pin driven while shared");
    AST_SLOT_RANGE: assert property (run |-> slot_ff <= last_slot) // R4
        else $error("slot past frame end");
    AST_IDLE_SLOT: assert property (rise && !any |=> dout_oe_n) // R6
        else $error("unused slot driven");
    AST_LAST_RELEASE: assert property // R7
        (fall && bit_ff == pvp_pkg::LAST_BIT |=> dout_oe_n)
        else $error("no release after last bit");
    AST_SHORT_SYNC: assert property (c_master && !c_long && fs_ff // R8
        |-> bit_ff == pvp_pkg::LAST_BIT && slot_ff == last_slot)
        else $error("short sync misplaced");
    AST_SLAVE_START: assert property (rise && pend_ff && run // R9
        |=> bit_ff == '0 && slot_ff == '0)
        else $error("slave frame not started");
    AST_LONG_SYNC: assert property (c_master && c_long && fs_ff // R10
        |-> slot_ff == '0 && bit_ff < pvp_pkg::LONG_SYNC_BITS)
        else $error("long sync misplaced");
    AST_REP_RANGE: assert property (rep_ff < rep_n || !run) // R17
        else $error("repeat count out of range");
    AST_REFUSE: assert property (state_ff == pvp_pkg::PVP_IDLE && start // R20
        && cfg_mux && cfg_mux_multi && !cfg_master |=> cfg_err)
        else $error("slave mixed rates accepted");
    AST_CFG_FROZEN: assert property (run |=> $stable(cfg_ff)) // R22
        else $error("config changed while running");
    AST_RELOAD: assert property (rise && at_end && run // R23
        |=> bit_ff == '0 && slot_ff == '0)
        else $error("counters not reloaded");
    COV_MASTER: cover property (run && c_master && rise && at_end);
    COV_SLAVE_LOCK: cover property (run && !c_master && $fell(fresh_ff));
    COV_RX_WORD: cover property (rx_valid && rx_ready);
    COV_MUX_REP: cover property (run && c_mux && rep_ff == 3'(rep_n - 3'h1));
endmodule

/* File: testbench/pvp_far_master.sv */
`timescale 1ns/1ps
// Far PCM master: 125 ns bit clock, short sync, one 16-bit slot
module pvp_far_master (
    // Control and words
    input wire logic en,
    input wire logic [15:0] pat,
    output logic frm,
    output logic [15:0] cap,
    output logic cap_stb,
    // PCM wires
    output logic bclk,
    output logic fsync,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe_n
);
    int b = 14;
    logic [15:0] w = '0;
    logic ok = 0;
    // Clock stands still until enabled
    initial
    begin
        {bclk, fsync, din, frm, cap, cap_stb} = '0;
        forever
        begin
            wait (en);
            #62.5 bclk = 1;
            b = (b + 1) % 16;
            frm = (b == 0);
            ok = ok || frm;
            fsync = (b == 15);
            // word MSB first in slot zero
            w = frm ? pat : w;
            din = w[15-b];
            #62.5 bclk = 0;
            cap[15-b] = dout;
            ok = ok && !dout_oe_n;
            cap_stb = (b == 15) && ok;
        end
    end
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
// Self-checking bench of the PCM voice port
module testbench;
    // Design inputs
    logic mclk, nrst, start, i2s_own, overrun_clr, cfg_master;
    logic cfg_long_sync, cfg_wideband_voice, cfg_lsb_first, cfg_mux;
    logic cfg_right_align, cfg_rate16, cfg_mux_multi, tx_valid, rx_ready;
    logic [2:0] cfg_slots_log2, cfg_fill_val, cfg_chan_en;
    logic [7:0] cfg_half;
    logic [1:0] cfg_fill, tx_chan, rx_chan;
    logic [11:0] cfg_chan_slot;
    // Design outputs and wires
    logic tx_ready, rx_valid, running, cfg_err, rx_overrun, bclk_o;
    logic bclk_oe_n, fsync_o, fsync_oe_n, dout_o, dout_oe_n, dout_pin;
    logic p_bclk, p_fsync, p_din, frm, cap_stb, en, chk;
    logic [15:0] tx_data, rx_data, pat, cap;
    // Expected words, oldest first
    logic [15:0] rxq[$], txq[$];
    int errors = 0, tests_run = 0, cyc = 0, n;

    pvp_voice_port i_dut (.mclk, .nrst, .start, .i2s_own, .cfg_master,
        .cfg_long_sync, .cfg_slots_log2, .cfg_half, .cfg_wideband_voice,
        .cfg_lsb_first, .cfg_right_align, .cfg_fill, .cfg_fill_val,
        .cfg_chan_en, .cfg_chan_slot, .cfg_mux, .cfg_rate16, .cfg_mux_multi,
        .tx_valid, .tx_ready, .tx_chan, .tx_data, .rx_valid, .rx_ready,
        .rx_chan, .rx_data, .running, .cfg_err, .rx_overrun, .overrun_clr,
        .bclk_i(bclk_oe_n ? p_bclk : bclk_o), .bclk_o, .bclk_oe_n,
        .fsync_i(fsync_oe_n ? p_fsync : fsync_o), .fsync_o, .fsync_oe_n,
        .din_i(p_din), .dout_o, .dout_oe_n);
    pvp_far_master i_far (.en, .pat, .frm, .cap, .cap_stb, .bclk(p_bclk),
        .fsync(p_fsync), .din(p_din), .dout(dout_pin), .dout_oe_n);

    // Released data line shows a changing level
    always @(dout_o or dout_oe_n)
        dout_pin = dout_oe_n ? !dout_pin : dout_o;
    // Clock
    initial
    begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end

    // Compare one value
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Settle past an edge
    task automatic settle(int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask

    // Cycle count and hang limit
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            errors++;
            stop_test;
        end
    end
    // New sample whenever one is taken
    always @(posedge mclk)
        if (tx_valid && tx_ready)
        begin
            if (chk)
                txq.push_back(tx_data);
            tx_data <= 16'($urandom);
        end
    // Note each word the far end sends
    always @(posedge frm)
    begin
        if (chk)
            rxq.push_back(pat);
        pat <= 16'($urandom);
    end
    // Received words against notes
    always @(posedge mclk)
        if (rx_valid && rx_ready && chk)
        begin
            check("rx_data", rx_data, rxq.pop_front());
            check("rx_chan", 16'(rx_chan), 16'h0000);
        end
    // Transmitted words against notes
    always @(posedge cap_stb)
        if (chk && txq.size() > 0)
            check("dout word", cap, txq.pop_front());

    // Main sequence
    initial
    begin
        n = $urandom(32'h1950);
        {nrst, start, i2s_own, overrun_clr, cfg_master, cfg_mux} = '0;
        {cfg_long_sync, cfg_lsb_first, cfg_right_align, cfg_rate16} = '0;
        {cfg_mux_multi, cfg_slots_log2, cfg_fill_val, cfg_half} = '0;
        {cfg_fill, cfg_chan_slot, tx_valid, tx_chan, rx_ready} = '0;
        {en, chk, pat, tx_data} = '0;
        cfg_wideband_voice = 1;
        cfg_chan_en = 3'h1;
        repeat (20) @(posedge mclk);
        nrst <= 1;
        settle(1);
        check("reset pins", 16'({bclk_oe_n, dout_oe_n, running}), 16'h6);
        $display("Reset test done");
        // Slave run with random stalls
        @(posedge mclk);
        chk <= 1;
        start <= 1;
        settle(3);
        check("slave", 16'({running, bclk_oe_n, fsync_oe_n}), 16'h7);
        @(posedge mclk);
        en <= 1;
        tx_valid <= 1;
        repeat (4000) @(posedge mclk) rx_ready <= ($urandom % 4) != 0;
        chk <= 0;
        rx_ready <= 0;
        settle(1200);
        check("overrun", 16'(rx_overrun), 16'h1);
        @(posedge mclk);
        start <= 0;
        en <= 0;
        overrun_clr <= 1;
        settle(3);
        check("stopped", 16'({running, rx_overrun, tx_ready}), 16'h0);
        $display("Slave test done");
        // Mixed rates refused as slave
        @(posedge mclk);
        {overrun_clr, cfg_mux, cfg_mux_multi, start} <= 4'hF;
        settle(3);
        check("refusal", 16'({running, cfg_err}), 16'h1);
        @(posedge mclk);
        start <= 0;
        settle(2);
        $display("Refusal test done");
        // Master, two slots, half period below the floor
        @(posedge mclk);
        {cfg_mux, cfg_mux_multi, cfg_master, start} <= 4'h3;
        cfg_half <= 8'h03;
        cfg_slots_log2 <= 3'h1;
        settle(3);
        check("master", 16'({bclk_oe_n, fsync_oe_n}), 16'h0);
        @(posedge bclk_o);
        n = cyc;
        @(posedge bclk_o);
        check("bclk period", 16'(cyc - n), 16'h000A);
        @(posedge fsync_o);
        n = cyc;
        @(negedge fsync_o);
        check("sync width", 16'(cyc - n), 16'h000A);
        settle(80);
        check("slot0 oe", 16'(dout_oe_n), 16'h0);
        settle(120);
        check("slot1 oe", 16'(dout_oe_n), 16'h1);
        @(posedge fsync_o);
        check("frame", 16'(cyc - n), 16'h0140);
        // Sound port takes the pins
        @(posedge mclk);
        i2s_own <= 1;
        settle(2);
        check("shared", 16'({dout_oe_n, bclk_oe_n}), 16'h3);
        $display("Master test done");
        stop_test;
    end
endmodule
